// ### shared/asm_pkg.sv
// package for the async sram module host controller
// assumes a 25 mhz clock; module timing is met by whole clock cycles
package asm_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int READ_CYCLE_TIME_NS = 35;
  localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
  localparam int READ_CYCLES =
    (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETENTION_RECOVERY_CYCLES = READ_CYCLES;
  localparam int DESEL_CYCLES_RAW =
    (DESELECT_TO_RETENTION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESEL_CYCLES = (DESEL_CYCLES_RAW < 1) ? 1 : DESEL_CYCLES_RAW;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYCLES);
  localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(RETENTION_RECOVERY_CYCLES);
  localparam logic [CNT_W-1:0] DESEL_CNT = CNT_W'(DESEL_CYCLES);
  // density code expected from this module size
  // bit1 is grounded on this size; bit0 high is our pick
  localparam logic [1:0] DENSITY_256K = 2'h1;

  typedef enum logic [2:0] {
    ASM_IDLE, ASM_SETUP, ASM_STROBE, ASM_RELEASE, ASM_READ,
    ASM_RET_ENTER, ASM_RETAIN, ASM_RECOVER
  } asm_state_e;

  // request from user logic
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] lanes;
    logic write;
  } asm_req_s;

  // pins driven to the module
  typedef struct packed {
    logic [ADDR_W-1:0] word_address_lines;
    logic [LANES-1:0] byte_lane_select_n;
    logic write_strobe_n;
    logic output_gate_n;
    logic [DATA_W-1:0] data_out;
    logic [LANES-1:0] data_oe;
  } asm_pins_s;
endpackage

// ### verilog/asm_sync.sv
// two-flop synchroniser for pins coming from the module
// assumes inputs are asynchronous to i_clock
`timescale 1ns/1ns
module asm_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// ### verilog/asm_host.sv
// host controller for an async 256k x 32 sram module
// assumes one 25 mhz clock; module pins are asynchronous to it
`timescale 1ns/1ns
module asm_host
  import asm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire asm_req_s i_req,
  input wire logic i_retain,
  input wire logic [DATA_W-1:0] i_data_lines,
  input wire logic [1:0] i_density_code,
  output logic o_req_ready,
  output logic o_rdata_valid,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_in_retention,
  output logic o_density_ok,
  output asm_pins_s o_pins
);
  // ==========================================================
  // reset release and input synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [DATA_W-1:0] data_s;
  logic [1:0] dens_s;
  logic retain_s;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  asm_sync #(.W(DATA_W + 3)) u_sync (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_async({i_data_lines, i_density_code, i_retain}),
    .o_sync({data_s, dens_s, retain_s})
  );

  // ==========================================================
  // state
  typedef struct packed {
    asm_state_e state;
    logic [CNT_W-1:0] cnt;
    asm_req_s req;
    asm_pins_s pins;
    logic ready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic in_ret;
    logic dens_ok;
  } asm_st_s;

  asm_st_s st_reg;
  asm_st_s st_next;

  function automatic asm_pins_s idle_pins(input logic [ADDR_W-1:0] a);
    asm_pins_s p;
    p.word_address_lines = a;
    p.byte_lane_select_n = {LANES{1'b1}};
    p.write_strobe_n = 1'b1;
    p.output_gate_n = 1'b1;
    p.data_out = '0;
    p.data_oe = '0;
    return p;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    // bit1 grounded, bit0 set for this density
    st_next.dens_ok = (dens_s == DENSITY_256K);
    case (st_reg.state)
      ASM_IDLE: begin
        st_next.pins = idle_pins(st_reg.pins.word_address_lines);
        if (retain_s) begin
          st_next.ready = 1'b0;
          st_next.cnt = DESEL_CNT;
          st_next.state = ASM_RET_ENTER;
        end else if (i_req_valid && st_reg.ready) begin
          st_next.ready = 1'b0;
          st_next.req = i_req;
          // address goes out a cycle before any select falls
          st_next.pins.word_address_lines = i_req.addr;
          st_next.state = ASM_SETUP;
        end
      end
      ASM_SETUP: begin
        st_next.pins.byte_lane_select_n = ~st_reg.req.lanes;
        if (st_reg.req.write) begin
          // gate stays high across the write cycle
          st_next.pins.output_gate_n = 1'b1;
          // only selected lanes get driven data
          st_next.pins.data_out = st_reg.req.wdata;
          st_next.pins.data_oe = st_reg.req.lanes;
          st_next.state = ASM_STROBE;
        end else begin
          st_next.pins.output_gate_n = 1'b0;
          // strobe held high for the whole read
          st_next.pins.write_strobe_n = 1'b1;
          st_next.cnt = READ_CNT;
          st_next.state = ASM_READ;
        end
      end
      ASM_STROBE: begin
        // strobe falls last, so it starts the write
        st_next.pins.write_strobe_n = 1'b0;
        st_next.state = ASM_RELEASE;
      end
      ASM_RELEASE: begin
        // strobe rises first and ends the write; data held one cycle
        st_next.pins.write_strobe_n = 1'b1;
        st_next.state = ASM_IDLE;
        st_next.ready = 1'b1;
      end
      ASM_READ: begin
        if (!st_reg.pins.output_gate_n) begin
          // word is caught by the first sync flop as selects rise
          if (st_reg.cnt <= 1) begin
            st_next.cnt = '0;
            st_next.pins = idle_pins(st_reg.pins.word_address_lines);
          end else begin
            st_next.cnt = st_reg.cnt - CNT_W'(1);
          end
        end else if (st_reg.cnt == CNT_W'(1)) begin
          // word has now crossed both sync flops
          st_next.rdata = data_s;
          st_next.rvalid = 1'b1;
          st_next.ready = 1'b1;
          st_next.state = ASM_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
      end
      ASM_RECOVER: begin
        // selects stay high one read cycle after retention ends
        st_next.pins = idle_pins(st_reg.pins.word_address_lines);
        if (st_reg.cnt <= 1) begin
          st_next.ready = 1'b1;
          st_next.state = ASM_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_W'(1);
        end
      end
      ASM_RET_ENTER: begin
        st_next.pins = idle_pins(st_reg.pins.word_address_lines);
        if (st_reg.cnt <= 1) begin
          st_next.in_ret = 1'b1;
          st_next.state = ASM_RETAIN;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_W'(1);
        end
      end
      ASM_RETAIN: begin
        // all selects held high while supply is low
        st_next.pins = idle_pins(st_reg.pins.word_address_lines);
        if (!retain_s) begin
          st_next.in_ret = 1'b0;
          st_next.cnt = RECOVER_CNT;
          st_next.state = ASM_RECOVER;
        end
      end
      default: begin
        st_next.state = ASM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.state <= ASM_IDLE;
      st_reg.cnt <= '0;
      st_reg.req <= '0;
      st_reg.pins <= '{word_address_lines: '0,
        byte_lane_select_n: '1, write_strobe_n: 1'b1,
        output_gate_n: 1'b1, data_out: '0, data_oe: '0};
      st_reg.ready <= 1'b1;
      st_reg.rvalid <= 1'b0;
      st_reg.rdata <= '0;
      st_reg.in_ret <= 1'b0;
      st_reg.dens_ok <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_req_ready = st_reg.ready;
  assign o_rdata_valid = st_reg.rvalid;
  assign o_rdata = st_reg.rdata;
  assign o_in_retention = st_reg.in_ret;
  assign o_density_ok = st_reg.dens_ok;
  assign o_pins = st_reg.pins;

  // ==========================================================
  // checks
  property p_write_gate;
    @(posedge i_clock) disable iff (!rst_n)
      !st_reg.pins.write_strobe_n |-> st_reg.pins.output_gate_n;
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("gate low during write");

  property p_lane_oe;
    @(posedge i_clock) disable iff (!rst_n)
      (st_reg.pins.data_oe & st_reg.pins.byte_lane_select_n) == '0;
  endproperty
  a_lane_oe: assert property (p_lane_oe)
    else $error("data driven on unselected lane");

  property p_no_contend;
    @(posedge i_clock) disable iff (!rst_n)
      (st_reg.pins.data_oe != '0) |-> st_reg.pins.output_gate_n;
  endproperty
  a_no_contend: assert property (p_no_contend)
    else $error("host drives while module may drive");

  property p_strobe_pulse;
    @(posedge i_clock) disable iff (!rst_n)
      $fell(st_reg.pins.write_strobe_n) |->
        $stable(st_reg.pins.byte_lane_select_n) ##1
        (st_reg.pins.write_strobe_n && st_reg.pins.data_oe != '0);
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("write strobe shape wrong");

  property p_addr_first;
    @(posedge i_clock) disable iff (!rst_n)
      $fell(&st_reg.pins.byte_lane_select_n) |->
        $stable(st_reg.pins.word_address_lines);
  endproperty
  a_addr_first: assert property (p_addr_first)
    else $error("address moved with select");

  property p_ret_desel;
    @(posedge i_clock) disable iff (!rst_n)
      st_reg.in_ret |-> &st_reg.pins.byte_lane_select_n;
  endproperty
  a_ret_desel: assert property (p_ret_desel)
    else $error("selected during retention");

  property p_recover;
    @(posedge i_clock) disable iff (!rst_n)
      $fell(st_reg.in_ret) |->
        (&st_reg.pins.byte_lane_select_n) [*2];
  endproperty
  a_recover: assert property (p_recover)
    else $error("access too soon after retention");

  property p_lanes;
    @(posedge i_clock) disable iff (!rst_n)
      (st_reg.state == ASM_SETUP) |=>
        (st_reg.pins.byte_lane_select_n == ~st_reg.req.lanes);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte selects do not match request");
endmodule

// ### testbench/asm_mem_model.sv
// behavioural model of the 256k x 32 async memory module
// assumes the bench resolves the shared data lines from all enables
`timescale 1ns/1ns
module asm_mem_model
  import asm_pkg::*;
#(
  parameter logic [1:0] DENSITY = 2'h1
) (
  input wire asm_pins_s i_pins,
  input wire logic [DATA_W-1:0] i_bus,
  output logic [DATA_W-1:0] o_drive,
  output logic [LANES-1:0] o_drive_en,
  output logic [1:0] o_density_code
);
  // ==========================================================
  // storage
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // level write: last value seen before the earlier rise wins
  always @(i_pins or i_bus) begin
    for (int l = 0; l < LANES; l++) begin
      if (!i_pins.byte_lane_select_n[l] && !i_pins.write_strobe_n) begin
        mem[i_pins.word_address_lines][8*l+:8] = i_bus[8*l+:8];
      end
    end
  end
  // ==========================================================
  // read drive
  always @* begin
    o_drive = mem[i_pins.word_address_lines];
    for (int l = 0; l < LANES; l++) begin
      o_drive_en[l] = !i_pins.byte_lane_select_n[l] &&
        !i_pins.output_gate_n && i_pins.write_strobe_n;
    end
  end
  assign o_density_code = DENSITY;
endmodule

// ### testbench/asm_host_tb.sv
// self-checking bench for the async memory host controller
// assumes the module model stands on the far side of the pins
`timescale 1ns/1ns
module asm_host_tb;
  import asm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic retain = 1'b0;
  logic flip = 1'b0;
  asm_req_s req = '0;
  logic [DATA_W-1:0] bus, drv, rd;
  logic [LANES-1:0] drv_en;
  logic [1:0] dens;
  logic ready, rvalid, in_ret, dens_ok;
  logic [DATA_W-1:0] rdata;
  asm_pins_s pins;
  int error_cnt = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  // undriven lanes toggle so a stale value cannot pass
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      bus[8*l+:8] = pins.data_oe[l] ? pins.data_out[8*l+:8] :
        drv_en[l] ? drv[8*l+:8] : {8{flip}};
    end
  end
  asm_host i_asm_host (.i_clock(clk), .i_rst_n(rst_n), .i_req_valid(valid),
    .i_req(req), .i_retain(retain), .i_data_lines(bus),
    .i_density_code(dens), .o_req_ready(ready), .o_rdata_valid(rvalid),
    .o_rdata(rdata), .o_in_retention(in_ret), .o_density_ok(dens_ok),
    .o_pins(pins));
  asm_mem_model i_asm_mem_model (.i_pins(pins), .i_bus(bus), .o_drive(drv),
    .o_drive_en(drv_en), .o_density_code(dens));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic access(input logic w, input logic [17:0] a,
      input logic [31:0] d, input logic [3:0] ln);
    int n;
    n = 0;
    valid = 1'b1;
    req = '{addr: a, wdata: d, lanes: ln, write: w};
    while (!ready && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    @(posedge clk) #1;
    valid = 1'b0;
    n = 0;
    while (!(w ? ready : rvalid) && n < 20) begin
      if (!pins.write_strobe_n) begin
        chk(32'(pins.output_gate_n), 32'h1);
        chk(32'(pins.byte_lane_select_n), {28'h0, ~ln});
      end
      @(posedge clk) #1;
      n++;
    end
    chk(32'(n < 20), 32'h1);
    rd = rdata;
  endtask
  function automatic logic [31:0] lmask(input logic [3:0] ln);
    for (int l = 0; l < LANES; l++) lmask[8*l+:8] = {8{ln[l]}};
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(32'({pins.byte_lane_select_n, pins.write_strobe_n,
      pins.output_gate_n, pins.data_oe}), 32'h3f0);
    chk(32'(ready), 32'h1);
  endtask
  task automatic t_full();
    access(1'b1, 18'h3ffff, 32'hdeadbeef, 4'hf);
    access(1'b0, 18'h3ffff, 32'h0, 4'hf);
    chk(rd, 32'hdeadbeef);
    chk(32'(dens_ok), 32'h1);
  endtask
  task automatic t_lanes();
    access(1'b1, 18'h00001, 32'h11223344, 4'hf);
    access(1'b1, 18'h00001, 32'haabbccdd, 4'h5);
    access(1'b0, 18'h00001, 32'h0, 4'hf);
    chk(rd, 32'h11bb33dd);
    access(1'b0, 18'h00001, 32'h0, 4'ha);
    chk(rd & lmask(4'ha), 32'h11003300);
  endtask
  task automatic t_retain();
    int n;
    n = 0;
    retain = 1'b1;
    while (!in_ret && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    chk(32'(in_ret), 32'h1);
    repeat (4) begin
      chk(32'(pins.byte_lane_select_n), 32'hf);
      @(posedge clk) #1;
    end
    retain = 1'b0;
    n = 0;
    while (in_ret && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    chk(32'(in_ret), 32'h0);
    chk(32'(ready), 32'h0);
    chk(32'(pins.byte_lane_select_n), 32'hf);
    access(1'b0, 18'h00001, 32'h0, 4'hf);
    chk(rd, 32'h11bb33dd);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_full();
    t_lanes();
    t_retain();
    wrap_up();
  end
  initial begin
    #(40 * 2000);
    error_cnt++;
    wrap_up();
  end
endmodule
